// File: pkg/dpbsc_pkg.sv
// Constants and types for the dual-port byte and flag access controller
package dpbsc_pkg;

  // ==========================================================================
  // Clock and timing
  // ==========================================================================
  localparam int CLK_PERIOD_NS = 10;
  // Address and selects settle before any strobe
  localparam int T_SETUP_NS    = 10;
  // Strobe width, one access time of the memory
  localparam int T_ACCESS_NS   = 15;
  // Data and address hold after the strobe ends
  localparam int T_HOLD_NS     = 10;
  // Test reset pulse after our own reset ends
  localparam int T_TAP_RST_NS  = 100;

  localparam int SETUP_CYC   = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACCESS_CYC  = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC    = (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TAP_RST_CYC = (T_TAP_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [3:0] SETUP_CNT   = 4'(SETUP_CYC - 1);
  localparam logic [3:0] ACCESS_CNT  = 4'(ACCESS_CYC - 1);
  localparam logic [3:0] HOLD_CNT    = 4'(HOLD_CYC - 1);
  localparam logic [3:0] TAP_RST_CNT = 4'(TAP_RST_CYC);

  // ==========================================================================
  // Widths and field positions
  // ==========================================================================
  localparam int ADDR_W      = 17;
  localparam int DATA_W      = 18;
  localparam int LANE_W      = 9;
  localparam int FLAG_IDX_W  = 3;
  localparam int LANE_UPPER  = 1;
  localparam int LANE_LOWER  = 0;

  // ==========================================================================
  // Values after reset
  // ==========================================================================
  localparam logic [3:0]        CNT_RST   = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_RST  = 17'h00000;
  localparam logic [DATA_W-1:0] DATA_RST  = 18'h00000;
  localparam logic [1:0]        LANES_OFF = 2'h3;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SETUP,
    ST_STROBE,
    ST_HOLD
  } dpbsc_fsm_type;

  typedef struct packed {
    dpbsc_fsm_type     state;
    logic [3:0]        cnt;
    logic              is_write;
    logic              ce0_n;
    logic              ce1;
    logic              rw;
    logic              oe_n;
    logic              sem_n;
    logic              ub_n;
    logic              lb_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dout;
    logic [1:0]        doe_n;
    logic [DATA_W-1:0] rdata;
    logic              ack;
  } dpbsc_regs_type;

  typedef struct packed {
    logic [3:0] cnt;
    logic       rst_n;
  } dpbsc_tap_type;

endpackage

// File: core/dpbsc_tap_reset.sv
// Test reset pulse generator for the memory's test access port
`timescale 1ns/10ps
module dpbsc_tap_reset (
  input  wire logic ref_clk_i,
  input  wire logic resetn_i,
  output logic      test_reset_n_o
);

  // ==========================================================================
  // State
  // ==========================================================================
  dpbsc_pkg::dpbsc_tap_type regs_ff;
  dpbsc_pkg::dpbsc_tap_type nxt_regs;

  always_comb begin
    nxt_regs = regs_ff;
    if (regs_ff.cnt != dpbsc_pkg::TAP_RST_CNT) begin
      nxt_regs.cnt = regs_ff.cnt + 4'h1;
    end
    // Held low through reset and a fixed time after it
    nxt_regs.rst_n = (regs_ff.cnt == dpbsc_pkg::TAP_RST_CNT);
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      regs_ff <= '{cnt: dpbsc_pkg::CNT_RST, rst_n: 1'b0};
    end else begin
      regs_ff <= nxt_regs;
    end
  end

  assign test_reset_n_o = regs_ff.rst_n;

  a_tap_reset_held: assert property (
    @(posedge ref_clk_i) disable iff (!resetn_i)
    (regs_ff.cnt != dpbsc_pkg::TAP_RST_CNT) |-> ##1 !test_reset_n_o)
    else $error("test reset released too early");

endmodule

// File: core/dpbsc_host.sv
// Host controller for one port of a dual-port memory with flag access
//
// Notes on behaviour
// - Write with upper select high, lower low: drive only lower lanes.
// - Write with upper select low, lower high: drive only upper lanes.
// - Flag write: flag select low, chip off, write low, lower low; lane 0 stored.
// - Flag read drives only lanes whose select is low; we pull selects low.
`timescale 1ns/10ps
module dpbsc_host (
  input  wire logic                         ref_clk_i,
  input  wire logic                         resetn_i,
  // User side
  input  wire logic                         req_i,
  input  wire logic                         req_write_i,
  input  wire logic                         req_flag_i,
  input  wire logic [dpbsc_pkg::ADDR_W-1:0] req_addr_i,
  input  wire logic [1:0]                   req_lanes_i,
  input  wire logic [dpbsc_pkg::DATA_W-1:0] req_wdata_i,
  output logic                              ready_o,
  output logic                              ack_o,
  output logic [dpbsc_pkg::DATA_W-1:0]      rdata_o,
  // Memory port pins
  output logic                              chip_enable_n_o,
  output logic                              chip_enable_active_high_o,
  output logic                              read_write_select_o,
  output logic                              output_enable_n_o,
  output logic                              flag_access_select_n_o,
  output logic                              upper_lane_select_n_o,
  output logic                              lower_lane_select_n_o,
  output logic [dpbsc_pkg::ADDR_W-1:0]      mem_addr_o,
  input  wire logic [dpbsc_pkg::DATA_W-1:0] mem_data_i,
  output logic [dpbsc_pkg::DATA_W-1:0]      mem_data_o,
  output logic [1:0]                        mem_data_oe_n_o,
  output logic                              test_reset_n_o
);

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [dpbsc_pkg::DATA_W-1:0] lane_mask(input logic ub_n, input logic lb_n);
    lane_mask = {{dpbsc_pkg::LANE_W{~ub_n}}, {dpbsc_pkg::LANE_W{~lb_n}}};
  endfunction

  // ==========================================================================
  // State
  // ==========================================================================
  dpbsc_pkg::dpbsc_regs_type regs_ff;
  dpbsc_pkg::dpbsc_regs_type nxt_regs;
  localparam dpbsc_pkg::dpbsc_regs_type REGS_RST = '{
    state:    dpbsc_pkg::ST_IDLE,
    cnt:      dpbsc_pkg::CNT_RST,
    is_write: 1'b0,
    ce0_n:    1'b1,
    ce1:      1'b0,
    rw:       1'b1,
    oe_n:     1'b1,
    sem_n:    1'b1,
    ub_n:     1'b1,
    lb_n:     1'b1,
    addr:     dpbsc_pkg::ADDR_RST,
    dout:     dpbsc_pkg::DATA_RST,
    doe_n:    dpbsc_pkg::LANES_OFF,
    rdata:    dpbsc_pkg::DATA_RST,
    ack:      1'b0
  };

  // ==========================================================================
  // Access sequencer
  // ==========================================================================
  always_comb begin
    nxt_regs     = regs_ff;
    nxt_regs.ack = 1'b0;
    case (regs_ff.state)
      dpbsc_pkg::ST_IDLE: begin
        if (req_i) begin
          nxt_regs.state    = dpbsc_pkg::ST_SETUP;
          nxt_regs.cnt      = dpbsc_pkg::SETUP_CNT;
          nxt_regs.is_write = req_write_i;
          if (req_flag_i) begin
            // Chip stays off during flag access; only the flag index goes out
            nxt_regs.ce0_n = 1'b1;
            nxt_regs.ce1   = 1'b0;
            nxt_regs.sem_n = 1'b0;
            nxt_regs.addr  = {{(dpbsc_pkg::ADDR_W - dpbsc_pkg::FLAG_IDX_W){1'b0}},
                              req_addr_i[dpbsc_pkg::FLAG_IDX_W-1:0]};
            if (req_write_i) begin
              // Only lane 0 matters, so only the lower group is driven
              nxt_regs.ub_n  = 1'b1;
              nxt_regs.lb_n  = 1'b0;
              nxt_regs.dout  = {{(dpbsc_pkg::DATA_W - 1){1'b0}}, req_wdata_i[0]};
              nxt_regs.doe_n = 2'b10;
            end else begin
              // Both selects low so every lane carries the flag
              nxt_regs.ub_n  = 1'b0;
              nxt_regs.lb_n  = 1'b0;
              nxt_regs.dout  = dpbsc_pkg::DATA_RST;
              nxt_regs.doe_n = dpbsc_pkg::LANES_OFF;
            end
          end else begin
            nxt_regs.ce0_n = 1'b0;
            nxt_regs.ce1   = 1'b1;
            nxt_regs.sem_n = 1'b1;
            nxt_regs.addr  = req_addr_i;
            nxt_regs.ub_n  = ~req_lanes_i[dpbsc_pkg::LANE_UPPER];
            nxt_regs.lb_n  = ~req_lanes_i[dpbsc_pkg::LANE_LOWER];
            if (req_write_i) begin
              // Unselected lanes stay released
              nxt_regs.dout  = req_wdata_i & lane_mask(~req_lanes_i[1], ~req_lanes_i[0]);
              nxt_regs.doe_n = ~req_lanes_i;
            end else begin
              nxt_regs.dout  = dpbsc_pkg::DATA_RST;
              nxt_regs.doe_n = dpbsc_pkg::LANES_OFF;
            end
          end
        end
      end
      dpbsc_pkg::ST_SETUP: begin
        if (regs_ff.cnt == 4'h0) begin
          nxt_regs.state = dpbsc_pkg::ST_STROBE;
          nxt_regs.cnt   = dpbsc_pkg::ACCESS_CNT;
          nxt_regs.rw    = ~regs_ff.is_write;
          nxt_regs.oe_n  = regs_ff.is_write;
        end else begin
          nxt_regs.cnt = regs_ff.cnt - 4'h1;
        end
      end
      dpbsc_pkg::ST_STROBE: begin
        if (regs_ff.cnt == 4'h0) begin
          nxt_regs.state = dpbsc_pkg::ST_HOLD;
          nxt_regs.cnt   = dpbsc_pkg::HOLD_CNT;
          nxt_regs.rw    = 1'b1;
          nxt_regs.oe_n  = 1'b1;
          if (!regs_ff.is_write) begin
            // Lanes not selected are floating, so they read as zero
            nxt_regs.rdata = mem_data_i & lane_mask(regs_ff.ub_n, regs_ff.lb_n);
          end
        end else begin
          nxt_regs.cnt = regs_ff.cnt - 4'h1;
        end
      end
      dpbsc_pkg::ST_HOLD: begin
        if (regs_ff.cnt == 4'h0) begin
          // Write data is held until the chip is off, for hold margin
          nxt_regs.state = dpbsc_pkg::ST_IDLE;
          nxt_regs.ce0_n = 1'b1;
          nxt_regs.ce1   = 1'b0;
          nxt_regs.sem_n = 1'b1;
          nxt_regs.ub_n  = 1'b1;
          nxt_regs.lb_n  = 1'b1;
          nxt_regs.doe_n = dpbsc_pkg::LANES_OFF;
          nxt_regs.ack   = 1'b1;
        end else begin
          nxt_regs.cnt = regs_ff.cnt - 4'h1;
        end
      end
      default: begin
        nxt_regs = REGS_RST;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      regs_ff <= REGS_RST;
    end else begin
      regs_ff <= nxt_regs;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign ready_o                   = (regs_ff.state == dpbsc_pkg::ST_IDLE);
  assign ack_o                     = regs_ff.ack;
  assign rdata_o                   = regs_ff.rdata;
  assign chip_enable_n_o           = regs_ff.ce0_n;
  assign chip_enable_active_high_o = regs_ff.ce1;
  assign read_write_select_o       = regs_ff.rw;
  assign output_enable_n_o         = regs_ff.oe_n;
  assign flag_access_select_n_o    = regs_ff.sem_n;
  assign upper_lane_select_n_o     = regs_ff.ub_n;
  assign lower_lane_select_n_o     = regs_ff.lb_n;
  assign mem_addr_o                = regs_ff.addr;
  assign mem_data_o                = regs_ff.dout;
  assign mem_data_oe_n_o           = regs_ff.doe_n;

  dpbsc_tap_reset u_tap_reset (
    .ref_clk_i      (ref_clk_i),
    .resetn_i       (resetn_i),
    .test_reset_n_o (test_reset_n_o)
  );

  // ==========================================================================
  // Checks
  // ==========================================================================
  a_lower_write_only: assert property (
    @(posedge ref_clk_i) disable iff (!resetn_i)
    (!read_write_select_o && flag_access_select_n_o && upper_lane_select_n_o && !lower_lane_select_n_o)
    |-> (mem_data_oe_n_o == 2'b10) && (mem_data_o[17:9] == 9'h000))
    else $error("lower-only write drives upper lanes");

  a_upper_write_only: assert property (
    @(posedge ref_clk_i) disable iff (!resetn_i)
    (!read_write_select_o && flag_access_select_n_o && !upper_lane_select_n_o && lower_lane_select_n_o)
    |-> (mem_data_oe_n_o == 2'b01) && (mem_data_o[8:0] == 9'h000))
    else $error("upper-only write drives lower lanes");

  a_flag_write_lane: assert property (
    @(posedge ref_clk_i) disable iff (!resetn_i)
    (!flag_access_select_n_o && !read_write_select_o)
    |-> chip_enable_n_o && !chip_enable_active_high_o && !lower_lane_select_n_o
        && !mem_data_oe_n_o[0] && (mem_data_o[17:1] == 17'h00000))
    else $error("flag write controls wrong");

  a_flag_read_sel: assert property (
    @(posedge ref_clk_i) disable iff (!resetn_i)
    (!flag_access_select_n_o && !output_enable_n_o)
    |-> !upper_lane_select_n_o && !lower_lane_select_n_o && chip_enable_n_o)
    else $error("flag read without lane selects");

  a_flag_index: assert property (
    @(posedge ref_clk_i) disable iff (!resetn_i)
    !flag_access_select_n_o |-> (mem_addr_o[16:3] == 14'h0000))
    else $error("flag address above three bits");

  a_read_released: assert property (
    @(posedge ref_clk_i) disable iff (!resetn_i)
    (!output_enable_n_o || (chip_enable_n_o && flag_access_select_n_o)) |-> (mem_data_oe_n_o == 2'b11))
    else $error("lanes driven while memory may drive");

  a_strobe_width: assert property (
    @(posedge ref_clk_i) disable iff (!resetn_i)
    $fell(read_write_select_o) |-> !read_write_select_o [*2] ##1 read_write_select_o)
    else $error("write strobe width wrong");

  a_ack_bound: assert property (
    @(posedge ref_clk_i) disable iff (!resetn_i)
    (req_i && ready_o) |-> ##5 ack_o)
    else $error("access did not finish in time");

endmodule

// File: tb/dpbsc_mem_model.sv
// Behavioural model of one memory port with its eight shared flags
`timescale 1ns/10ps
module dpbsc_mem_model (
  input  wire logic        ce0_n_i,
  input  wire logic        ce1_i,
  input  wire logic        rw_i,
  input  wire logic        oe_n_i,
  input  wire logic        sem_n_i,
  input  wire logic        ub_n_i,
  input  wire logic        lb_n_i,
  input  wire logic [16:0] addr_i,
  input  wire logic [17:0] host_data_i,
  input  wire logic [1:0]  host_oe_n_i,
  input  wire logic        test_reset_n_i,
  output logic      [17:0] bus_o,
  output int               faults_o,
  output logic             tap_ok_o
);
  // ==========================================================================
  // Storage and read drive
  // ==========================================================================
  logic [17:0] mem [256];
  logic [7:0]  flags = 8'hff;
  logic        sel;
  logic        rd;
  logic [1:0]  dev_en;
  logic [17:0] dev_val;
  initial faults_o = 0;
  initial bus_o = 18'h00000;
  assign sel     = !ce0_n_i && ce1_i;
  assign rd      = rw_i && !oe_n_i && (sem_n_i ? sel : !sel);
  assign dev_en  = {2{rd}} & ~{ub_n_i, lb_n_i};
  assign dev_val = sem_n_i ? mem[addr_i[7:0]] : {18{flags[addr_i[2:0]]}};
  // Released lanes flip so a stale value never passes for data
  always @(host_data_i, host_oe_n_i, dev_en, dev_val) begin
    for (int l = 0; l < 2; l++) begin
      if (!host_oe_n_i[l]) bus_o[l*9 +: 9] = host_data_i[l*9 +: 9];
      else if (dev_en[l]) bus_o[l*9 +: 9] = dev_val[l*9 +: 9];
      else bus_o[l*9 +: 9] = ~bus_o[l*9 +: 9];
    end
  end
  // Judged late: host pins move on one edge but settle in any order
  always @(host_oe_n_i, dev_en, ub_n_i, lb_n_i, sem_n_i, sel) begin
    #1;
    if (|(~host_oe_n_i & (dev_en | {ub_n_i, lb_n_i}))) faults_o++;
    if (!sem_n_i && sel) faults_o++;
  end
  // ==========================================================================
  // Writes, taken as the strobe ends
  // ==========================================================================
  always @(posedge rw_i) begin
    if (sem_n_i && sel) begin
      if (!ub_n_i) mem[addr_i[7:0]][17:9] = bus_o[17:9];
      if (!lb_n_i) mem[addr_i[7:0]][8:0] = bus_o[8:0];
    end else if (!sem_n_i && !sel && !lb_n_i) flags[addr_i[2:0]] = bus_o[0];
  end
  always @(test_reset_n_i) begin
    if (test_reset_n_i === 1'b0) tap_ok_o = 1'b1;
  end
endmodule

// File: tb/testbench.sv
// Self-checking bench for the one-port host controller
`timescale 1ns/10ps
module testbench;
  typedef struct packed {
    logic        w;
    logic [16:0] a;
    logic [1:0]  l;
    logic [17:0] d;
  } dpbsc_row_type;
  // Writes carry data, reads carry the expected word
  dpbsc_row_type rows [9] = '{
    '{1'h1, 17'h00003, 2'h3, {9'h1a5, 9'h05a}}, '{1'h0, 17'h00003, 2'h3, {9'h1a5, 9'h05a}},
    '{1'h1, 17'h00003, 2'h1, {9'h0ff, 9'h123}}, '{1'h1, 17'h00003, 2'h2, {9'h0c3, 9'h1ff}},
    '{1'h0, 17'h00003, 2'h3, {9'h0c3, 9'h123}}, '{1'h0, 17'h00003, 2'h2, {9'h0c3, 9'h000}},
    '{1'h0, 17'h00003, 2'h1, {9'h000, 9'h123}}, '{1'h1, 17'h00003, 2'h0, {9'h1ff, 9'h1ff}},
    '{1'h0, 17'h00003, 2'h3, {9'h0c3, 9'h123}}};
  logic        ref_clk_i = 1'h0;
  logic        resetn_i = 1'h0;
  logic        req_i = 1'h0;
  logic        req_write_i = 1'h0;
  logic        req_flag_i = 1'h0;
  logic [16:0] req_addr_i = 17'h00000;
  logic [1:0]  req_lanes_i = 2'h0;
  logic [17:0] req_wdata_i = 18'h00000;
  logic        ready, ack, ce0_n, ce1, rw, oe_n, sem_n, ub_n, lb_n, trst_n, tap_ok;
  logic [16:0] maddr;
  logic [17:0] rdata, bus, mdout, held;
  logic [1:0]  moe_n;
  int          faults, fail_count, num_checks, n;
  // Falling edges from the taking edge to the ack cycle: setup, strobe, hold, then ack
  localparam int ACK_NEG = dpbsc_pkg::SETUP_CYC + dpbsc_pkg::ACCESS_CYC + dpbsc_pkg::HOLD_CYC + 1;
  dpbsc_host u_dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .req_i(req_i), .req_write_i(req_write_i),
    .req_flag_i(req_flag_i), .req_addr_i(req_addr_i), .req_lanes_i(req_lanes_i), .req_wdata_i(req_wdata_i),
    .ready_o(ready), .ack_o(ack), .rdata_o(rdata), .chip_enable_n_o(ce0_n), .chip_enable_active_high_o(ce1),
    .read_write_select_o(rw), .output_enable_n_o(oe_n), .flag_access_select_n_o(sem_n),
    .upper_lane_select_n_o(ub_n), .lower_lane_select_n_o(lb_n), .mem_addr_o(maddr), .mem_data_i(bus),
    .mem_data_o(mdout), .mem_data_oe_n_o(moe_n), .test_reset_n_o(trst_n));
  dpbsc_mem_model u_mem (.ce0_n_i(ce0_n), .ce1_i(ce1), .rw_i(rw), .oe_n_i(oe_n), .sem_n_i(sem_n), .ub_n_i(ub_n),
    .lb_n_i(lb_n), .addr_i(maddr), .host_data_i(mdout), .host_oe_n_i(moe_n), .test_reset_n_i(trst_n),
    .bus_o(bus), .faults_o(faults), .tap_ok_o(tap_ok));
  initial begin
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic check(input logic [17:0] seen, input logic [17:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic put(input logic w, f, input logic [16:0] a, input logic [1:0] l, input logic [17:0] d);
    req_i <= 1'h1;
    req_write_i <= w;
    req_flag_i <= f;
    req_addr_i <= a;
    req_lanes_i <= l;
    req_wdata_i <= d;
  endtask
  // Counts falling edges from the taking edge up to the ack cycle
  task automatic wait_ack();
    n = 0;
    do begin
      @(negedge ref_clk_i);
      n++;
    end while (ack !== 1'h1 && n < 20);
    if (n >= 20) begin
      fail_count++;
      give_verdict();
    end
  endtask
  task automatic access(input logic w, f, input logic [16:0] a, input logic [1:0] l, input logic [17:0] d);
    @(posedge ref_clk_i);
    put(w, f, a, l, d);
    @(posedge ref_clk_i);
    req_i <= 1'h0;
    wait_ack();
    if (!w) held = d;
    check(18'(n), 18'(ACK_NEG));
    check(rdata, held);
  endtask
  task automatic idle_pins();
    @(negedge ref_clk_i);
    check({ce0_n, ce1, rw, oe_n, sem_n, ub_n, lb_n, moe_n, ready, ack, trst_n}, 18'h00bfc);
  endtask
  task automatic wait_tap();
    @(posedge ref_clk_i);
    resetn_i <= 1'h1;
    n = 0;
    while (trst_n !== 1'h1 && n < 40) begin
      @(negedge ref_clk_i);
      n++;
    end
    check({trst_n, tap_ok}, 18'h00003);
    if (n >= 40) begin
      give_verdict();
    end
  endtask
  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    held = 18'h00000;
    repeat (4) @(posedge ref_clk_i);
    idle_pins();
    wait_tap();
    $display("test reset done");
    foreach (rows[i]) access(rows[i].w, 1'h0, rows[i].a, rows[i].l, rows[i].d);
    $display("test array rows done");
    // Only lane 0 may reach a flag; the rest carry the opposite value
    for (int i = 0; i < 8; i++) access(1'h1, 1'h1, {14'h3fff, 3'(i)}, 2'h0, {{17{~i[0]}}, i[0]});
    for (int i = 0; i < 8; i++) access(1'h0, 1'h1, 17'(i), 2'h0, {18{i[0]}});
    access(1'h0, 1'h0, 17'h00003, 2'h3, {9'h0c3, 9'h123});
    $display("test flags done");
    // A request held through a busy write is taken in the ack cycle
    @(posedge ref_clk_i);
    put(1'h1, 1'h0, 17'h1ffff, 2'h3, 18'h2d2d2);
    @(posedge ref_clk_i);
    put(1'h0, 1'h0, 17'h1ffff, 2'h3, 18'h00000);
    wait_ack();
    check(18'(n), 18'(ACK_NEG));
    @(posedge ref_clk_i);
    req_i <= 1'h0;
    wait_ack();
    check(18'(n), 18'(ACK_NEG));
    check(rdata, 18'h2d2d2);
    $display("test back to back done");
    // Reset in mid-read: pins fall back to idle at once
    @(posedge ref_clk_i);
    put(1'h0, 1'h0, 17'h00003, 2'h3, 18'h00000);
    @(posedge ref_clk_i);
    req_i <= 1'h0;
    repeat (2) @(posedge ref_clk_i);
    resetn_i <= 1'h0;
    idle_pins();
    check(rdata, 18'h00000);
    wait_tap();
    held = 18'h00000;
    access(1'h0, 1'h0, 17'h00003, 2'h3, {9'h0c3, 9'h123});
    check(18'(faults), 18'h00000);
    $display("test mid reset done");
    give_verdict();
  end
endmodule
